// file: hdl/smc_pkg.sv
package smc_pkg;

    // =====================================================================
    // Register map
    // =====================================================================
    localparam logic [7:0] SERIAL_BUS_CONFIGURATION_ADDR  = 8'hC1;
    localparam logic [7:0] SERIAL_BUS_CONFIGURATION_RESET = 8'h00;

    // =====================================================================
    // Field positions
    // =====================================================================
    localparam int INTERFACE_ENABLE_BIT_POS     = 7;
    localparam int SLAVE_INHIBIT_BIT_POS        = 6;
    localparam int TRANSFER_BUSY_FLAG_POS       = 5;
    localparam int HOLD_EXTENSION_BIT_POS       = 4;
    localparam int CLOCK_LOW_TIMEOUT_ENABLE_POS = 3;
    localparam int BUS_FREE_TIMEOUT_ENABLE_POS  = 2;
    localparam int BIT_RATE_SOURCE_SELECT_LSB   = 0;

    // =====================================================================
    // Bit-rate source codes
    // =====================================================================
    typedef enum logic [1:0] {
        SMC_SRC_TIMER0      = 2'h0,
        SMC_SRC_TIMER1      = 2'h1,
        SMC_SRC_TIMER2_HIGH = 2'h2,
        SMC_SRC_TIMER2_LOW  = 2'h3
    } smc_src_t;

    // =====================================================================
    // Timing counts
    // =====================================================================
    localparam logic [3:0] FREE_TIMEOUT_PERIODS = 4'hA;
    localparam logic [3:0] SETUP_NORMAL_CYCLES  = 4'h1;
    localparam logic [3:0] HOLD_NORMAL_CYCLES   = 4'h3;
    localparam logic [3:0] SETUP_EXTEND_CYCLES  = 4'hB;
    localparam logic [3:0] HOLD_EXTEND_CYCLES   = 4'hC;

endpackage : smc_pkg

// file: hdl/smc_sync2.sv
`timescale 1ns/1ps

// Two-flop synchroniser; only the second stage leaves the module.
module smc_sync2 #(
    parameter int WIDTH = 1
) (
    input  wire logic             i_clk,
    input  wire logic             i_reset_n,
    input  wire logic [WIDTH-1:0] i_async,
    output logic      [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] meta_q;
    logic [WIDTH-1:0] meta_d;
    logic [WIDTH-1:0] sync_q;
    logic [WIDTH-1:0] sync_d;

    always_comb begin
        meta_d = i_async;
        sync_d = meta_q;
    end

    always_ff @(posedge i_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            meta_q <= '0;
            sync_q <= '0;
        end else begin
            meta_q <= meta_d;
            sync_q <= sync_d;
        end
    end

    assign o_sync = sync_q;

endmodule : smc_sync2

// file: hdl/smc_config_ctrl.sv
`timescale 1ns/1ps

// Summary of operation
// - Enable bit active: interface runs and watches both lines; cleared disables it.
// - Slave inhibit suppresses slave interrupts only; master interrupts still pass.
// - Busy flag sets during a transfer, clears on STOP or free timeout.
// - Hold extension bit picks normal or extended SDA setup and hold minimums.
// - Clock-low timeout: helper timer reloads while SCL high, counts while low.
// - In split mode only the helper timer's high byte is held in reload.
// - Free timeout: bus free after both lines high over 10 source periods.
// - Two-bit source field chooses timer 0, 1, 2 high or 2 low overflow.
// - While inhibited, lines are still watched and every address gets NACK.
// - Inhibit takes effect only at the next START condition.
// - Selected source is used only as master or with free timeout enabled.
module smc_config_ctrl (
    input  wire logic       i_sys_clk,
    input  wire logic       i_reset_n,
    input  wire logic       i_link_clk,
    input  wire logic [7:0] i_sfr_addr,
    input  wire logic       i_sfr_wr,
    input  wire logic [7:0] i_sfr_wdata,
    output logic      [7:0] o_sfr_rdata,
    input  wire logic       i_port_data_line,
    input  wire logic       i_port_clock_line,
    input  wire logic       i_timer0_ovf,
    input  wire logic       i_timer1_ovf,
    input  wire logic       i_timer2_high_ovf,
    input  wire logic       i_timer2_low_ovf,
    input  wire logic       i_master_active,
    input  wire logic       i_helper_timer_split,
    input  wire logic       i_slave_event,
    input  wire logic       i_master_event,
    output logic            o_interface_active,
    output logic            o_bit_rate_tick,
    output logic            o_helper_reload_high,
    output logic            o_helper_reload_low,
    output logic            o_helper_count_en,
    output logic            o_slave_irq,
    output logic            o_master_irq,
    output logic            o_address_nack,
    output logic      [3:0] o_sda_setup_cycles,
    output logic      [3:0] o_sda_hold_cycles
);

    // =====================================================================
    // Link domain: START and STOP detection on the line-sampling clock
    // =====================================================================
    logic [1:0] link_lines;
    logic       link_sda_prev_q;
    logic       link_sda_prev_d;
    logic       start_tgl_q;
    logic       start_tgl_d;
    logic       stop_tgl_q;
    logic       stop_tgl_d;

    smc_sync2 #(.WIDTH(2)) u_link_sync (
        .i_clk     (i_link_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_port_clock_line, i_port_data_line}),
        .o_sync    (link_lines)
    );

    // Lines idle high; prev resets high, but the synchronised lines start low, so a false STOP follows reset.
    always_comb begin
        link_sda_prev_d = link_lines[0];
        start_tgl_d     = start_tgl_q;
        stop_tgl_d      = stop_tgl_q;
        if (link_lines[1] && link_sda_prev_q && !link_lines[0]) begin
            start_tgl_d = ~start_tgl_q;
        end
        if (link_lines[1] && !link_sda_prev_q && link_lines[0]) begin
            stop_tgl_d = ~stop_tgl_q;
        end
    end

    always_ff @(posedge i_link_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            link_sda_prev_q <= 1'b1;
            start_tgl_q     <= 1'b0;
            stop_tgl_q      <= 1'b0;
        end else begin
            link_sda_prev_q <= link_sda_prev_d;
            start_tgl_q     <= start_tgl_d;
            stop_tgl_q      <= stop_tgl_d;
        end
    end

    // =====================================================================
    // Crossing into the system domain
    // =====================================================================
    logic [3:0] sys_sync;
    logic       scl_s;
    logic       sda_s;
    logic       start_tgl_s;
    logic       stop_tgl_s;

    // Pins are also synchronised directly so SCL level tracking does not wait
    // on the link-clock domain.
    smc_sync2 #(.WIDTH(4)) u_sys_sync (
        .i_clk     (i_sys_clk),
        .i_reset_n (i_reset_n),
        .i_async   ({i_port_clock_line, i_port_data_line, start_tgl_q, stop_tgl_q}),
        .o_sync    (sys_sync)
    );

    assign scl_s       = sys_sync[3];
    assign sda_s       = sys_sync[2];
    assign start_tgl_s = sys_sync[1];
    assign stop_tgl_s  = sys_sync[0];

    // =====================================================================
    // System domain state
    // =====================================================================
    logic [7:0] cfg_q;
    logic [7:0] cfg_d;
    logic       busy_q;
    logic       busy_d;
    logic       inh_eff_q;
    logic       inh_eff_d;
    logic       start_seen_q;
    logic       start_seen_d;
    logic       stop_seen_q;
    logic       stop_seen_d;
    logic [3:0] free_cnt_q;
    logic [3:0] free_cnt_d;
    logic [7:0] rdata_q;
    logic [7:0] rdata_d;
    logic       active_q;
    logic       active_d;
    logic       tick_q;
    logic       tick_d;
    logic       rld_hi_q;
    logic       rld_hi_d;
    logic       rld_lo_q;
    logic       rld_lo_d;
    logic       cnt_en_q;
    logic       cnt_en_d;
    logic       sirq_q;
    logic       sirq_d;
    logic       mirq_q;
    logic       mirq_d;
    logic       nack_q;
    logic       nack_d;
    logic [3:0] setup_q;
    logic [3:0] setup_d;
    logic [3:0] hold_q;
    logic [3:0] hold_d;

    logic       enable;
    logic       inhibit;
    logic       ext_hold;
    logic       toe;
    logic       fte;
    logic       toe_on;
    logic       src_ovf;
    logic       start_pulse;
    logic       stop_pulse;
    logic       lines_high;
    logic       free_event;

    // =====================================================================
    // Configuration fields
    // =====================================================================
    assign enable   = cfg_q[smc_pkg::INTERFACE_ENABLE_BIT_POS];
    assign inhibit  = cfg_q[smc_pkg::SLAVE_INHIBIT_BIT_POS];
    assign ext_hold = cfg_q[smc_pkg::HOLD_EXTENSION_BIT_POS];
    assign toe      = cfg_q[smc_pkg::CLOCK_LOW_TIMEOUT_ENABLE_POS];
    assign fte      = cfg_q[smc_pkg::BUS_FREE_TIMEOUT_ENABLE_POS];
    assign toe_on   = enable & toe;

    // Timer overflows come from logic on this clock, so they need no synchroniser.
    always_comb begin
        case (smc_pkg::smc_src_t'(cfg_q[smc_pkg::BIT_RATE_SOURCE_SELECT_LSB +: 2]))
            smc_pkg::SMC_SRC_TIMER0:      src_ovf = i_timer0_ovf;
            smc_pkg::SMC_SRC_TIMER1:      src_ovf = i_timer1_ovf;
            smc_pkg::SMC_SRC_TIMER2_HIGH: src_ovf = i_timer2_high_ovf;
            smc_pkg::SMC_SRC_TIMER2_LOW:  src_ovf = i_timer2_low_ovf;
            default:                      src_ovf = 1'b0;
        endcase
    end

    // A toggle that differs from its last sampled copy marks one event.
    assign start_pulse = start_tgl_s ^ start_seen_q;
    assign stop_pulse  = stop_tgl_s ^ stop_seen_q;
    assign lines_high  = scl_s & sda_s;
    assign free_event  = enable & fte & lines_high & src_ovf
                         & (free_cnt_q == smc_pkg::FREE_TIMEOUT_PERIODS);

    // =====================================================================
    // System domain next state
    // =====================================================================
    always_comb begin
        cfg_d        = cfg_q;
        start_seen_d = start_tgl_s;
        stop_seen_d  = stop_tgl_s;
        if (i_sfr_wr && (i_sfr_addr == smc_pkg::SERIAL_BUS_CONFIGURATION_ADDR)) begin
            cfg_d = i_sfr_wdata;
        end
        // The busy position is never stored; it is merged in on read.
        cfg_d[smc_pkg::TRANSFER_BUSY_FLAG_POS] = 1'b0;

        free_cnt_d = free_cnt_q;
        if (!(enable && fte && lines_high)) begin
            free_cnt_d = 4'h0;
        end else if (src_ovf && (free_cnt_q <= smc_pkg::FREE_TIMEOUT_PERIODS)) begin
            free_cnt_d = free_cnt_q + 4'h1;
        end

        // A START in the same cycle as a STOP or free timeout wins, since a new transfer began; disable still clears.
        busy_d = busy_q;
        if (!enable || stop_pulse || free_event) begin
            busy_d = 1'b0;
        end
        if (enable && start_pulse) begin
            busy_d = 1'b1;
        end

        // Inhibit is armed only at a START so the current transfer finishes.
        inh_eff_d = inh_eff_q;
        if (!inhibit) begin
            inh_eff_d = 1'b0;
        end else if (start_pulse) begin
            inh_eff_d = 1'b1;
        end

        rdata_d = 8'h00;
        if (i_sfr_addr == smc_pkg::SERIAL_BUS_CONFIGURATION_ADDR) begin
            rdata_d                                  = cfg_q;
            rdata_d[smc_pkg::TRANSFER_BUSY_FLAG_POS] = busy_q;
        end

        active_d = enable;
        tick_d   = enable & (i_master_active | fte) & src_ovf;
        rld_hi_d = toe_on & scl_s;
        rld_lo_d = toe_on & scl_s & ~i_helper_timer_split;
        cnt_en_d = ~(toe_on & scl_s);
        sirq_d   = enable & i_slave_event & ~inh_eff_q;
        mirq_d   = enable & i_master_event;
        nack_d   = enable & inh_eff_q;
        setup_d  = ext_hold ? smc_pkg::SETUP_EXTEND_CYCLES : smc_pkg::SETUP_NORMAL_CYCLES;
        hold_d   = ext_hold ? smc_pkg::HOLD_EXTEND_CYCLES : smc_pkg::HOLD_NORMAL_CYCLES;
    end

    always_ff @(posedge i_sys_clk or negedge i_reset_n) begin
        if (!i_reset_n) begin
            cfg_q        <= smc_pkg::SERIAL_BUS_CONFIGURATION_RESET;
            busy_q       <= 1'b0;
            inh_eff_q    <= 1'b0;
            start_seen_q <= 1'b0;
            stop_seen_q  <= 1'b0;
            free_cnt_q   <= 4'h0;
            rdata_q      <= 8'h00;
            active_q     <= 1'b0;
            tick_q       <= 1'b0;
            rld_hi_q     <= 1'b0;
            rld_lo_q     <= 1'b0;
            cnt_en_q     <= 1'b0;
            sirq_q       <= 1'b0;
            mirq_q       <= 1'b0;
            nack_q       <= 1'b0;
            setup_q      <= smc_pkg::SETUP_NORMAL_CYCLES;
            hold_q       <= smc_pkg::HOLD_NORMAL_CYCLES;
        end else begin
            cfg_q        <= cfg_d;
            busy_q       <= busy_d;
            inh_eff_q    <= inh_eff_d;
            start_seen_q <= start_seen_d;
            stop_seen_q  <= stop_seen_d;
            free_cnt_q   <= free_cnt_d;
            rdata_q      <= rdata_d;
            active_q     <= active_d;
            tick_q       <= tick_d;
            rld_hi_q     <= rld_hi_d;
            rld_lo_q     <= rld_lo_d;
            cnt_en_q     <= cnt_en_d;
            sirq_q       <= sirq_d;
            mirq_q       <= mirq_d;
            nack_q       <= nack_d;
            setup_q      <= setup_d;
            hold_q       <= hold_d;
        end
    end

    assign o_sfr_rdata          = rdata_q;
    assign o_interface_active   = active_q;
    assign o_bit_rate_tick      = tick_q;
    assign o_helper_reload_high = rld_hi_q;
    assign o_helper_reload_low  = rld_lo_q;
    assign o_helper_count_en    = cnt_en_q;
    assign o_slave_irq          = sirq_q;
    assign o_master_irq         = mirq_q;
    assign o_address_nack       = nack_q;
    assign o_sda_setup_cycles   = setup_q;
    assign o_sda_hold_cycles    = hold_q;

endmodule : smc_config_ctrl

// file: tb/smc_asserts.sv
`timescale 1ns/1ps
module smc_asserts (
    input wire logic       i_sys_clk,
    input wire logic       i_reset_n,
    input wire logic       i_timer0_ovf,
    input wire logic       i_timer1_ovf,
    input wire logic       i_timer2_high_ovf,
    input wire logic       i_timer2_low_ovf,
    input wire logic       o_interface_active,
    input wire logic       o_bit_rate_tick,
    input wire logic       o_helper_reload_high,
    input wire logic       o_helper_reload_low,
    input wire logic       o_helper_count_en,
    input wire logic       o_slave_irq,
    input wire logic       o_master_irq,
    input wire logic       o_address_nack,
    input wire logic [3:0] o_sda_setup_cycles,
    input wire logic [3:0] o_sda_hold_cycles
);
    logic ovf;
    assign ovf = i_timer0_ovf | i_timer1_ovf | i_timer2_high_ovf | i_timer2_low_ovf;
    default clocking cb @(posedge i_sys_clk); endclocking
    default disable iff (!i_reset_n);
    hold_value_a: assert property (o_sda_hold_cycles inside {4'h3, 4'hC})
        else $error("hold count illegal");
    setup_pair_a: assert property ((o_sda_setup_cycles == 4'hB) == (o_sda_hold_cycles == 4'hC))
        else $error("setup and hold disagree");
    idle_irq_a: assert property (!o_interface_active |-> !o_slave_irq && !o_master_irq)
        else $error("irq while disabled");
    tick_cause_a: assert property (o_bit_rate_tick |-> ovf || $past(ovf) || $past(ovf, 2))
        else $error("tick without overflow");
    split_reload_a: assert property (o_helper_reload_low |-> o_helper_reload_high)
        else $error("low byte reload alone");
    count_reload_a: assert property (o_helper_count_en |-> !o_helper_reload_high)
        else $error("count during reload");
    master_irq_a: assert property (o_master_irq |-> o_interface_active)
        else $error("master irq while disabled");
    nack_active_a: assert property (o_address_nack |-> o_interface_active)
        else $error("nack while disabled");
    cover property (o_bit_rate_tick);
    cover property (o_helper_count_en);
    cover property (o_master_irq);
endmodule : smc_asserts
bind smc_config_ctrl smc_asserts smc_asserts_i (.*);

// file: tb/smc_bus_model.sv
`timescale 1ns/1ps
// One frame: START, clock pulses, STOP; both lines idle high by pull-up.
module smc_bus_model (
    input  wire logic i_link_clk,
    input  wire logic i_go,
    output logic      o_sda,
    output logic      o_scl
);
    logic [5:0] n_q = 6'h00;
    always @(posedge i_link_clk)
        if (n_q != 6'h00 || i_go) n_q <= (n_q == 6'h28) ? 6'h00 : n_q + 6'h01;
    assign o_scl = !(n_q >= 6'h02 && n_q < 6'h26 && n_q[1]);
    assign o_sda = !(n_q >= 6'h01 && n_q < 6'h27);
endmodule : smc_bus_model

// file: tb/testbench.sv
`timescale 1ns/1ps
module testbench;
    logic clk = 0, lclk = 0, rst_n = 0, wr = 0, go = 0, sclt = 1, spl = 0, ma = 0, mev = 0, sev = 0;
    logic [7:0] wd = 8'h00, rd;
    logic [3:0] ovf = 4'h0, su, ho;
    logic sda, scl, act, tk, rh, rl, ce, sirq, nk;
    int n_errors = 0, check_count = 0, nt = 0, nm = 0, b, k;
    always #20 clk = ~clk;
    always #15 lclk = ~lclk;
    smc_bus_model smc_bus_model_i (.i_link_clk(lclk), .i_go(go), .o_sda(sda), .o_scl(scl));
    smc_config_ctrl smc_config_ctrl_i (.i_sys_clk(clk), .i_reset_n(rst_n), .i_link_clk(lclk),
        .i_sfr_addr(8'hC1), .i_sfr_wr(wr), .i_sfr_wdata(wd), .o_sfr_rdata(rd),
        .i_port_data_line(sda), .i_port_clock_line(scl & sclt), .i_timer0_ovf(ovf[0]),
        .i_timer1_ovf(ovf[1]), .i_timer2_high_ovf(ovf[2]), .i_timer2_low_ovf(ovf[3]),
        .i_master_active(ma), .i_helper_timer_split(spl), .i_slave_event(sev),
        .i_master_event(mev), .o_interface_active(act), .o_bit_rate_tick(tk),
        .o_helper_reload_high(rh), .o_helper_reload_low(rl), .o_helper_count_en(ce),
        .o_slave_irq(sirq), .o_master_irq(), .o_address_nack(nk), .o_sda_setup_cycles(su),
        .o_sda_hold_cycles(ho));
    always @(negedge clk) nt += tk;
    task chk(input string s, input logic [7:0] g, input logic [7:0] e);
        check_count++;
        if (g !== e) begin
            n_errors++;
            $display("FAIL %s exp %h got %h", s, e, g);
        end
    endtask : chk
    task wt(input logic [7:0] d);
        @(negedge clk); wr = 1; wd = d;
        @(negedge clk); wr = 0;
        repeat (4) @(negedge clk);
    endtask : wt
    task pulse(input logic [3:0] v);
        ovf = v; @(negedge clk); ovf = 4'h0;
        repeat (4) @(negedge clk);
    endtask : pulse
    task test_done;
        $display("errors %0d checks %0d", n_errors, check_count);
        if (n_errors == 0 && check_count > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask : test_done
    task t_reg;
        chk("cfg", rd, 8'h00);
        wt(8'hFF); chk("cfg", rd, 8'hDF);
        chk("hold", ho, 4'hC);
        chk("setup", su, 4'hB);
        wt(8'h00); chk("hold", ho, 4'h3);
    endtask : t_reg
    task t_toe;
        wt(8'h88); chk("act", act, 1);
        chk("rh", rh, 1);
        sclt = 0;
        repeat (4) @(negedge clk); chk("ce", ce, 1);
        spl = 1; sclt = 1; repeat (4) @(negedge clk); chk("rl", {rh, rl}, 2);
        spl = 0; wt(8'h00); chk("act", act, 0);
    endtask : t_toe
    task t_src;
        ma = 1;
        for (k = 0; k < 4; k++) begin
            wt(8'h80 | k[7:0]); b = nt; pulse(4'hF ^ (4'h1 << k)); pulse(4'h1 << k);
            chk("tick", 8'(nt - b), 8'h01);
        end
        ma = 0; wt(8'h81); b = nt; pulse(4'hF); chk("tick", 8'(nt - b), 8'h00);
    endtask : t_src
    task t_busy;
        wt(8'hC4); chk("nack", nk, 0);
        go = 1; @(negedge clk); go = 0;
        repeat (10) @(negedge clk); chk("busy", rd[5], 1);
        chk("nack", nk, 1);
        sev = 1; @(negedge clk); chk("sirq", sirq, 0);
        sev = 0;
        repeat (40) @(negedge clk); chk("busy", rd[5], 0);
        wt(8'h80); sev = 1; @(negedge clk); chk("sirq", sirq, 1);
        sev = 0;
        mev = 1; @(negedge clk); b = smc_config_ctrl_i.o_master_irq; mev = 0;
        @(negedge clk); chk("mirq", b | smc_config_ctrl_i.o_master_irq, 1);
        wt(8'h00);
    endtask : t_busy
    initial begin
        repeat (20) @(negedge clk); rst_n = 1;
        repeat (2) @(negedge clk); t_reg; t_toe; t_src; t_busy; test_done;
    end
    initial begin
        #200000; n_errors++; test_done;
    end
endmodule : testbench
